// ### hdl/ddc_pkg.sv
// Shared constants for the dead-time correcting PWM generator.
package ddc_pkg;
	localparam int DDC_PHASES = 3;
	localparam int DDC_VW = 16;
	localparam int DDC_DW = 8;
	localparam logic [7:0] DDC_OFF_CTRL = 8'h00;
	localparam logic [7:0] DDC_OFF_PERIOD = 8'h04;
	localparam logic [7:0] DDC_OFF_DEAD = 8'h08;
	localparam logic [7:0] DDC_OFF_VAL0 = 8'h0C;
	localparam logic [7:0] DDC_OFF_SENSE = 8'h24;
	localparam logic [7:0] DDC_OFF_STATUS = 8'h28;
	localparam int DDC_CTRL_RUN = 0;
	localparam int DDC_CTRL_CENTER = 1;
	localparam int DDC_CTRL_CORR = 2;
	localparam logic [2:0] DDC_CTRL_RST = 3'h0;
	localparam logic [15:0] DDC_PERIOD_RST = 16'h0100;
	localparam logic [7:0] DDC_DEAD_RST = 8'h10;
	localparam logic [15:0] DDC_VAL_RST = 16'h0000;
endpackage

// ### hdl/ddc_deadband.sv
// One half-bridge: complementary gates with dead interval and sense sampling.
`timescale 1ns/1ps
`default_nettype none
module ddc_deadband
	import ddc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic ref_i,
	input wire logic [DDC_DW-1:0] dead_i,
	input wire logic sense_i,
	output logic top_o,
	output logic bot_o,
	output logic rise_smp_o,
	output logic fall_smp_o,
	output logic smp_stb_o
);
	logic tgt, in_dead;
	logic [DDC_DW-1:0] cnt;
	logic next_tgt, next_in_dead, next_top, next_bot;
	logic next_rise, next_fall, next_stb;
	logic [DDC_DW-1:0] next_cnt;

	// Both gates come from the single reference, so they cannot overlap.
	always_comb
	begin
		next_tgt = tgt;
		next_in_dead = in_dead;
		next_cnt = cnt;
		next_top = top_o;
		next_bot = bot_o;
		next_rise = rise_smp_o;
		next_fall = fall_smp_o;
		next_stb = 1'b0;
		if (!en_i)
		begin
			next_tgt = 1'b0;
			next_in_dead = 1'b0;
			next_cnt = '0;
			next_top = 1'b0;
			next_bot = 1'b0;
		end
		else if (ref_i != tgt)
		begin
			// Turn both off first; a dead value of zero still gives one cycle.
			next_tgt = ref_i;
			next_in_dead = 1'b1;
			next_cnt = dead_i;
			next_top = 1'b0;
			next_bot = 1'b0;
		end
		else if (in_dead)
		begin
			if (cnt <= 8'h01)
			begin
				// End of the dead interval: sample, then switch on.
				next_in_dead = 1'b0;
				next_top = tgt;
				next_bot = ~tgt;
				next_stb = 1'b1;
				if (tgt)
					next_rise = sense_i;
				else
					next_fall = sense_i;
			end
			else
				next_cnt = cnt - 8'h01;
		end
	end

	// Register the gate state.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			tgt <= 1'b0;
			in_dead <= 1'b0;
			cnt <= '0;
			top_o <= 1'b0;
			bot_o <= 1'b0;
			rise_smp_o <= 1'b0;
			fall_smp_o <= 1'b0;
			smp_stb_o <= 1'b0;
		end
		else
		begin
			tgt <= next_tgt;
			in_dead <= next_in_dead;
			cnt <= next_cnt;
			top_o <= next_top;
			bot_o <= next_bot;
			rise_smp_o <= next_rise;
			fall_smp_o <= next_fall;
			smp_stb_o <= next_stb;
		end
	end
endmodule
`default_nettype wire

// ### hdl/ddc_pwm.sv
// Three-phase complementary PWM with dead-time distortion correction.
`timescale 1ns/1ps
`default_nettype none
module ddc_pwm
	import ddc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [DDC_PHASES-1:0] sense_i,
	output logic [DDC_PHASES-1:0] gate_top_o,
	output logic [DDC_PHASES-1:0] gate_bot_o
);
	logic [2:0] ctrl, next_ctrl;
	logic [DDC_VW-1:0] period, next_period;
	logic [DDC_DW-1:0] dead, next_dead;
	logic [DDC_VW-1:0] val [2*DDC_PHASES];
	logic [DDC_VW-1:0] next_val [2*DDC_PHASES];
	logic [DDC_VW-1:0] act [DDC_PHASES];
	logic [DDC_VW-1:0] next_act [DDC_PHASES];
	logic [DDC_VW-1:0] cnt, next_cnt;
	logic down, next_down, bound, next_bound;
	logic [DDC_PHASES-1:0] pol, next_pol, ref_q, next_ref;
	logic [DDC_PHASES-1:0] sync1, sync2;
	logic [DDC_PHASES-1:0] rise_smp, fall_smp, smp_stb;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr_en;
	logic [2*DDC_PHASES-1:0] sense_bits;

	// Two flops on each sense pin before anything looks at it.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= sense_i;
			sync2 <= sync1;
		end
	end

	// A write lands only at the edge where the completer answers.
	assign wr_en = psel_i & penable_i & pready_o & pwrite_i;

	// Register file writes.
	always_comb
	begin
		next_ctrl = ctrl;
		next_period = period;
		next_dead = dead;
		for (int i = 0; i < 2*DDC_PHASES; i++)
			next_val[i] = val[i];
		if (wr_en)
		begin
			if (paddr_i == DDC_OFF_CTRL)
				next_ctrl = pwdata_i[2:0];
			else if (paddr_i == DDC_OFF_PERIOD)
				next_period = pwdata_i[DDC_VW-1:0];
			else if (paddr_i == DDC_OFF_DEAD)
				next_dead = pwdata_i[DDC_DW-1:0];
			for (int i = 0; i < 2*DDC_PHASES; i++)
				if (paddr_i == DDC_OFF_VAL0 + 8'(4*i))
					next_val[i] = pwdata_i[DDC_VW-1:0];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			ctrl <= DDC_CTRL_RST;
			period <= DDC_PERIOD_RST;
			dead <= DDC_DEAD_RST;
			for (int i = 0; i < 2*DDC_PHASES; i++)
				val[i] <= DDC_VAL_RST;
		end
		else
		begin
			ctrl <= next_ctrl;
			period <= next_period;
			dead <= next_dead;
			for (int i = 0; i < 2*DDC_PHASES; i++)
				val[i] <= next_val[i];
		end
	end

	// Each phase reports the sample of its rising and falling dead interval.
	always_comb
	begin
		for (int p = 0; p < DDC_PHASES; p++)
		begin
			sense_bits[2*p] = rise_smp[p];
			sense_bits[2*p+1] = fall_smp[p];
		end
	end

	// APB answer: one wait state, so reads always see settled data.
	always_comb
	begin
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = prdata_o;
		if (psel_i && penable_i && !pready_o)
		begin
			next_pready = 1'b1;
			next_prdata = '0;
			if (paddr_i == DDC_OFF_CTRL)
				next_prdata = {29'h0000_0000, ctrl};
			else if (paddr_i == DDC_OFF_PERIOD)
				next_prdata = {16'h0000, period};
			else if (paddr_i == DDC_OFF_DEAD)
				next_prdata = {24'h00_0000, dead};
			else if (paddr_i == DDC_OFF_SENSE)
				next_prdata = {26'h000_0000, sense_bits};
			else if (paddr_i == DDC_OFF_STATUS)
				next_prdata = {29'h0000_0000, pol};
			else if (paddr_i >= DDC_OFF_VAL0 && paddr_i < DDC_OFF_SENSE
				&& paddr_i[1:0] == 2'b00)
			begin
				for (int i = 0; i < 2*DDC_PHASES; i++)
					if (paddr_i == DDC_OFF_VAL0 + 8'(4*i))
						next_prdata = {16'h0000, val[i]};
			end
			else
				next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end
		else
		begin
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
			prdata_o <= next_prdata;
		end
	end

	// Period counter: saw-tooth or up/down; up/down doubles the period length.
	always_comb
	begin
		next_cnt = cnt;
		next_down = down;
		next_bound = 1'b0;
		if (!ctrl[DDC_CTRL_RUN])
		begin
			next_cnt = '0;
			next_down = 1'b0;
			next_bound = 1'b1;
		end
		else if (!ctrl[DDC_CTRL_CENTER])
		begin
			next_down = 1'b0;
			if (cnt + 16'h0001 >= period)
			begin
				next_cnt = '0;
				next_bound = 1'b1;
			end
			else
				next_cnt = cnt + 16'h0001;
		end
		else if (!down)
		begin
			if (cnt >= period)
			begin
				next_down = 1'b1;
				next_cnt = (cnt == 16'h0000) ? cnt : cnt - 16'h0001;
			end
			else
				next_cnt = cnt + 16'h0001;
		end
		else if (cnt == 16'h0000)
		begin
			next_down = 1'b0;
			next_bound = 1'b1;
			next_cnt = (period == 16'h0000) ? cnt : 16'h0001;
		end
		else
			next_cnt = cnt - 16'h0001;
	end

	// Polarity follows each sample; the selection it drives moves at bounds.
	always_comb
	begin
		next_pol = pol;
		for (int p = 0; p < DDC_PHASES; p++)
		begin
			if (smp_stb[p])
				next_pol[p] = sync2[p] ? 1'b1 : 1'b0;
			next_act[p] = act[p];
			if (bound)
			begin
				if (ctrl[DDC_CTRL_CORR] && pol[p])
					next_act[p] = val[2*p+1];
				else
					next_act[p] = val[2*p];
			end
			next_ref[p] = ctrl[DDC_CTRL_RUN] && (cnt < act[p]);
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			down <= 1'b0;
			bound <= 1'b0;
			pol <= '0;
			ref_q <= '0;
			for (int p = 0; p < DDC_PHASES; p++)
				act[p] <= DDC_VAL_RST;
		end
		else
		begin
			cnt <= next_cnt;
			down <= next_down;
			bound <= next_bound;
			pol <= next_pol;
			ref_q <= next_ref;
			for (int p = 0; p < DDC_PHASES; p++)
				act[p] <= next_act[p];
		end
	end

	// One dead-band stage per phase.
	for (genvar p = 0; p < DDC_PHASES; p++)
	begin : g_phase
		ddc_deadband u_db
		(
			.mclk_i(mclk_i),
			.rst_i(rst_i),
			.en_i(ctrl[DDC_CTRL_RUN]),
			.ref_i(ref_q[p]),
			.dead_i(dead),
			.sense_i(sync2[p]),
			.top_o(gate_top_o[p]),
			.bot_o(gate_bot_o[p]),
			.rise_smp_o(rise_smp[p]),
			.fall_smp_o(fall_smp[p]),
			.smp_stb_o(smp_stb[p])
		);
	end
endmodule
`default_nettype wire

// ### dv/ddc_pwm_asserts.sv
// Checker on the bus handshake and gate timing of the PWM top.
`timescale 1ns/1ps
`default_nettype none
module ddc_pwm_asserts
	import ddc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [DDC_PHASES-1:0] sense_i,
	input wire logic [DDC_PHASES-1:0] gate_top_o,
	input wire logic [DDC_PHASES-1:0] gate_bot_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Addresses past the status word and unaligned words are the only places that answer with error.
	wire logic bad = paddr_i > DDC_OFF_STATUS || paddr_i[1:0] != 2'h0;
	wire logic rd = pready_o && !pwrite_i;
	sequence wait_s;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence pulse_s;
		pready_o ##1 !pready_o;
	endsequence
	a_one_wait: assert property (wait_s |=> pulse_s)
		else $error("ready not one cycle after access");
	a_ready_cause: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside access");
	a_err_exact: assert property (pready_o |-> pslverr_o == bad)
		else $error("error flag wrong");
	a_sense_bits: assert property (rd && paddr_i == DDC_OFF_SENSE |->
		prdata_o[31:6] == 26'h0) else $error("sense word too wide");
	a_pol_bits: assert property (rd && paddr_i == DDC_OFF_STATUS |->
		prdata_o[31:3] == 29'h0) else $error("status word too wide");
	a_no_overlap: assert property ((gate_top_o & gate_bot_o) == 3'h0)
		else $error("both gates on");
	a_gap_bot: assert property ((gate_bot_o & $past(gate_top_o)) == 3'h0)
		else $error("bottom on without dead gap");
	a_gap_top: assert property ((gate_top_o & $past(gate_bot_o)) == 3'h0)
		else $error("top on without dead gap");
endmodule
bind ddc_pwm ddc_pwm_asserts chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .sense_i(sense_i),
	.gate_top_o(gate_top_o), .gate_bot_o(gate_bot_o));
`default_nettype wire

// ### dv/ddc_bridge_model.sv
// Inverter leg stand-in: the phase voltage seen on each sense pin.
`timescale 1ns/1ps
`default_nettype none
module ddc_bridge_model
	import ddc_pkg::*;
(
	input wire logic [DDC_PHASES-1:0] top_i,
	input wire logic [DDC_PHASES-1:0] bot_i,
	input wire logic [DDC_PHASES-1:0] neg_i,
	output logic [DDC_PHASES-1:0] sense_o
);
	// A driven leg sets the level; in dead time the winding current decides.
	always_comb
	begin
		sense_o = top_i | (~top_i & ~bot_i & neg_i);
	end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the dead-time correcting PWM.
`timescale 1ns/1ps
`default_nettype none
module tb
	import ddc_pkg::*;
;
	logic mclk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, gerr;
	logic [7:0] pa = 0;
	logic [31:0] pwd = 0, prd, got;
	logic prdy, perr;
	logic [2:0] sense, top, bot, neg = 0;
	logic [15:0] r1 [3], r2 [3];
	int fail_count = 0, checks = 0, seed = 31262, cyc = 0, w;
	`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
		fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
	initial forever #4 mclk_i = ~mclk_i;
	ddc_pwm dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .sense_i(sense),
		.gate_top_o(top), .gate_bot_o(bot));
	ddc_bridge_model br_u (.top_i(top), .bot_i(bot), .neg_i(neg),
		.sense_o(sense));
	// One bus transfer; an idle edge follows so strobes never double up.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwr <= wr;
		pa <= a;
		pwd <= d;
		@(posedge mclk_i);
		pen <= 1'b1;
		do @(posedge mclk_i); while (prdy !== 1'b1);
		got = prd;
		gerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge mclk_i);
	endtask
	// Counts the cycles of one whole high pulse of a gate.
	task automatic meas(input int b, input int p, output int n);
		n = 0;
		@(posedge mclk_i iff (b ? bot[p] : top[p]) === 1'b0);
		@(posedge mclk_i iff (b ? bot[p] : top[p]) === 1'b1);
		while ((b ? bot[p] : top[p]) === 1'b1)
		begin
			n++;
			@(posedge mclk_i);
		end
	endtask
	// Gate width for period 64 and dead 4; dead time comes off each gate.
	// The up/down count visits zero once per period, so a centred pulse
	// stands for one count less than twice its value.
	function automatic int exp_w(int v, int ctr, int b);
		int h;
		h = ctr ? 2 * v - 1 : v;
		if (b)
			h = (ctr ? 128 : 64) - h;
		return h - 4;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// A hang ends the run as a mismatch.
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 44; a += 4)
		begin
			apb(0, 8'(a), 0);
			`CHK("rst", a == 4 ? 256 : a == 8 ? 16 : 0, got)
		end
		apb(0, 8'h2C, 0);
		`CHK("err", 1'b1, gerr)
		apb(1, DDC_OFF_SENSE, 32'hFFFF_FFFF);
		apb(0, DDC_OFF_SENSE, 0);
		`CHK("ro", 0, got)
		apb(1, DDC_OFF_PERIOD, 64);
		apb(1, DDC_OFF_DEAD, 4);
		for (int p = 0; p < 3; p++)
		begin
			w = 12 + {$random(seed)} % 29;
			r1[p] = 16'(w + 4);
			r2[p] = 16'(w - 4);
			apb(1, DDC_OFF_VAL0 + 8'(8 * p), 32'(r1[p]));
			apb(1, DDC_OFF_VAL0 + 8'(8 * p + 4), 32'(r2[p]));
			apb(0, DDC_OFF_VAL0 + 8'(8 * p + 4), 0);
			`CHK("val", 32'(r2[p]), got)
		end
		$display("register tests done");
		// Off with negative current, then on with each polarity, both modes.
		for (int m = 0; m < 6; m++)
		begin
			neg <= m / 2 == 1 ? 3'h0 : 3'h7;
			apb(1, DDC_OFF_CTRL, 32'(1 + 2 * (m % 2) + (m > 1 ? 4 : 0)));
			repeat (400) @(posedge mclk_i);
			for (int p = 0; p < 3; p++)
			begin
				meas(0, p, w);
				`CHK("top", exp_w(m > 3 ? r2[p] : r1[p], m % 2, 0), w)
			end
			meas(1, 0, w);
			`CHK("bot", exp_w(m > 3 ? r2[0] : r1[0], m % 2, 1), w)
			apb(0, DDC_OFF_STATUS, 0);
			`CHK("pol", 32'(neg), got)
			apb(0, DDC_OFF_SENSE, 0);
			`CHK("sense", neg[0] ? 63 : 0, got)
			$display("mode %0d done", m);
		end
		apb(1, DDC_OFF_CTRL, 0);
		repeat (4) @(posedge mclk_i);
		`CHK("off", 6'h0, {top, bot})
		tally_and_finish();
	end
endmodule
`default_nettype wire
